// ==== bench/rmc_far_model.sv ====
// Behavioural far side of the register map core: external register bank and external memory.
`timescale 1ns/1ps
module rmc_far_model #(
  parameter int ERR_IDX = 15
) (
  input wire logic hclk,
  input wire logic ext_req,
  input wire logic ext_we,
  input wire logic [rmc_pkg::EXT_IDX_W-1:0] ext_idx,
  input wire logic [rmc_pkg::REG_W-1:0] ext_wdata,
  output logic [rmc_pkg::REG_W-1:0] ext_rdata,
  output logic ext_ack,
  output logic ext_err,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [rmc_pkg::MEM_IDX_W-1:0] mem_idx,
  input wire logic [rmc_pkg::MEM_ENTRY_W-1:0] mem_wdata,
  output logic [rmc_pkg::MEM_ENTRY_W-1:0] mem_rdata,
  output logic mem_ack
);
  logic [rmc_pkg::REG_W-1:0] regs [rmc_pkg::EXT_REGS];
  logic [rmc_pkg::MEM_ENTRY_W-1:0] store [rmc_pkg::MEM_ENTRIES];
  logic [rmc_pkg::EXT_IDX_W-1:0] ei;
  logic [rmc_pkg::MEM_IDX_W-1:0] mi;
  initial begin
    {ext_rdata, ext_ack, ext_err, mem_rdata, mem_ack} = '0;
  end
  // Odd indices answer three cycles late, so prompt and slow completions both occur.
  always @(posedge hclk) begin
    if (ext_req) begin
      ei = ext_idx;
      if (ext_we && ei != ERR_IDX) regs[ei] = ext_wdata;
      repeat (ei[0] ? 3 : 0) @(posedge hclk);
      ext_rdata <= regs[ei];
      ext_err <= (ei == ERR_IDX);
      ext_ack <= 1'b1;
      @(posedge hclk);
      ext_ack <= 1'b0;
      ext_err <= 1'b0;
      // Released data lines show the inverse so stale data never passes.
      ext_rdata <= ~regs[ei];
    end
  end
  // Storage lives here only; every entry is readable and writable.
  always @(posedge hclk) begin
    if (mem_req) begin
      mi = mem_idx;
      if (mem_we) store[mi] = mem_wdata;
      repeat (mi[0] ? 3 : 0) @(posedge hclk);
      mem_rdata <= store[mi];
      mem_ack <= 1'b1;
      @(posedge hclk);
      mem_ack <= 1'b0;
      mem_rdata <= ~store[mi];
    end
  end
endmodule

// ==== bench/testbench.sv ====
// Self-checking bench for the register map core with random and corner stimulus.
`timescale 1ns/1ps
module testbench;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel, hwrite, hreadyout, hresp, b_wr, intr_summary, halt_summary, rsp;
  logic [1:0] htrans;
  logic [2:0] hsize, sz;
  logic [1:0] a;
  logic [31:0] haddr, hwdata, hrdata, b_wdata, b_rdata, rdv, lo, hi;
  logic [rmc_pkg::EVT_W-1:0] evt, en, mk, he, hm, ev;
  logic ext_req, ext_we, ext_ack, ext_err, mem_req, mem_we, mem_ack;
  logic [rmc_pkg::EXT_IDX_W-1:0] ext_idx;
  logic [rmc_pkg::REG_W-1:0] ext_wdata, ext_rdata;
  logic [rmc_pkg::MEM_IDX_W-1:0] mem_idx;
  logic [rmc_pkg::MEM_ENTRY_W-1:0] mem_wdata, mem_rdata;
  logic [rmc_pkg::MEM_IDX_W-1:0] mi [4];
  logic [31:0] dv [4];
  logic [11:0] holes [3] = '{12'h01C, 12'h080, 12'h200};
  int errors = 0;
  int total_checks = 0;
  int cycles = 0;

  rmc_core rmc_core_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .evt, .intr_summary, .halt_summary,
    .b_wr, .b_wdata, .b_rdata, .ext_req, .ext_we, .ext_idx, .ext_wdata, .ext_rdata, .ext_ack,
    .ext_err, .mem_req, .mem_we, .mem_idx, .mem_wdata, .mem_rdata, .mem_ack);
  rmc_far_model rmc_far_model_i (.hclk, .ext_req, .ext_we, .ext_idx, .ext_wdata, .ext_rdata,
    .ext_ack, .ext_err, .mem_req, .mem_we, .mem_idx, .mem_wdata, .mem_rdata, .mem_ack);

  always #2.5 hclk = ~hclk;

  task automatic close_out;
    if (errors == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // The run needs several hundred cycles; the ceiling leaves ample margin for slow answers.
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      close_out();
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One single transfer; entered just after a rising edge, left at the edge that completes it.
  task automatic ahb(input logic wr, input logic [11:0] ad, input logic [2:0] s, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {20'h0, ad};
    hwrite <= wr;
    hsize <= s;
    htrans <= rmc_pkg::HTRANS_NONSEQ;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rdv = hrdata;
    rsp = hresp;
  endtask

  task automatic wr(input logic [11:0] ad, input logic [31:0] wd);
    ahb(1'b1, ad, rmc_pkg::HSIZE_WORD, wd);
  endtask

  task automatic rd(input logic [11:0] ad);
    ahb(1'b0, ad, rmc_pkg::HSIZE_WORD, 32'h0);
  endtask

  function automatic logic summ(input logic [3:0] s, input logic [3:0] g, input logic [3:0] m);
    return |(s & g & ~m);
  endfunction

  function automatic logic [31:0] lane(input logic [31:0] w, input logic [1:0] ad, input logic [2:0] s);
    return w & ((s == 3'h0) ? (32'hFF << (8 * ad)) : (32'hFFFF << (16 * ad[1])));
  endfunction

  initial begin
    void'($urandom(32'hD525));
    {hsel, hwrite, b_wr} = '0;
    htrans = 2'h0;
    hsize = rmc_pkg::HSIZE_WORD;
    {haddr, hwdata, b_wdata, evt} = '0;
    repeat (6) @(posedge hclk);
    check("hreadyout", hreadyout, 1'b1);
    check("intr", intr_summary, 1'b0);
    check("halt", halt_summary, 1'b0);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int i = 0; i < 10; i++) begin
      {en, mk, he, hm, ev} = 20'($urandom);
      if (i < 2) {en, mk, he, hm} = i ? 16'h0 : 16'hF0F0;
      wr(rmc_pkg::OFF_ENABLE, en);
      wr(rmc_pkg::OFF_MASK, mk);
      wr(rmc_pkg::OFF_HALT_EN, he);
      wr(rmc_pkg::OFF_HALT_MASK, hm);
      evt <= ev;
      @(posedge hclk);
      evt <= 4'h0;
      repeat (2) @(posedge hclk);
      check("intr", intr_summary, summ(ev, en, mk));
      check("halt", halt_summary, summ(ev, he, hm));
      rd(rmc_pkg::OFF_CAPTURE);
      check("capture", rdv[0], summ(ev, en, mk));
      rd(rmc_pkg::OFF_STATUS);
      check("status", rdv, ev);
      wr(rmc_pkg::OFF_STATUS, ev);
      repeat (2) @(posedge hclk);
      check("intr cleared", intr_summary, 1'b0);
    end
    wr(rmc_pkg::OFF_ALIAS, 32'h5);
    rd(rmc_pkg::OFF_STATUS);
    check("alias to status", rdv, 32'h5);
    wr(rmc_pkg::OFF_STATUS, 32'h4);
    rd(rmc_pkg::OFF_ALIAS);
    check("status to alias", rdv, 32'h1);
    // An event that arrives during a clear must survive it.
    evt <= 4'h3;
    wr(rmc_pkg::OFF_STATUS, 32'hF);
    evt <= 4'h0;
    rd(rmc_pkg::OFF_STATUS);
    check("set beats clear", rdv, 32'h3);
    wr(rmc_pkg::OFF_STATUS, 32'hF);
    b_wdata <= $urandom;
    b_wr <= 1'b1;
    @(posedge hclk);
    b_wr <= 1'b0;
    rd(rmc_pkg::OFF_SHARED);
    check("shared by bus", rdv, b_wdata);
    wr(rmc_pkg::OFF_SHARED, ~b_wdata);
    @(posedge hclk);
    check("shared by port", b_rdata, ~b_wdata);
    lo = $urandom;
    hi = $urandom;
    wr(rmc_pkg::OFF_SCR_LO, lo);
    wr(rmc_pkg::OFF_SCR_HI, hi);
    // A narrow write would split a writable field, so it must leave the word alone.
    ahb(1'b1, rmc_pkg::OFF_SCR_LO, 3'h0, ~lo);
    rd(rmc_pkg::OFF_SCR_LO);
    check("scratch low", rdv, lo);
    for (int k = 0; k < 6; k++) begin
      sz = (k < 4) ? 3'h0 : 3'h1;
      a = 2'(k < 4 ? k : 2 * (k - 4));
      ahb(1'b0, rmc_pkg::OFF_SCR_HI + a, sz, 32'h0);
      check("partial read", rdv, lane(hi, a, sz));
    end
    rd(rmc_pkg::OFF_SCR_HI);
    check("scratch high", rdv, hi);
    wr(rmc_pkg::OFF_LOWF, 32'hFFFF_FFFF);
    rd(rmc_pkg::OFF_LOWF);
    check("low first packing", rdv, 32'h001F_FF0F);
    wr(rmc_pkg::OFF_HIGHF, 32'hFFFF_FFFF);
    rd(rmc_pkg::OFF_HIGHF);
    check("high first packing", rdv, 32'hF0FF_F800);
    for (int k = 0; k < 4; k++) begin
      dv[k] = $urandom;
      wr(12'(rmc_pkg::EXT_BASE + 4 * k), dv[k]);
      check("ext write resp", rsp, 1'b0);
    end
    for (int k = 0; k < 4; k++) begin
      rd(12'(rmc_pkg::EXT_BASE + 4 * k));
      check("ext read", rdv, dv[k]);
    end
    ahb(1'b1, rmc_pkg::EXT_BASE, 3'h0, ~dv[0]);
    rd(rmc_pkg::EXT_BASE);
    check("ext narrow write", rdv, dv[0]);
    rd(12'(rmc_pkg::EXT_BASE + 4 * 15));
    check("ext error resp", rsp, 1'b1);
    for (int k = 0; k < 4; k++) begin
      mi[k] = 6'(k == 0 ? 0 : k == 1 ? 63 : k == 2 ? $urandom_range(30, 1) : $urandom_range(62, 32));
      dv[k] = $urandom;
      wr(12'(rmc_pkg::MEM_BASE + rmc_pkg::VREG_BYTES * mi[k]), dv[k]);
    end
    for (int k = 0; k < 4; k++) begin
      rd(12'(rmc_pkg::MEM_BASE + rmc_pkg::VREG_BYTES * mi[k]));
      check("memory entry", rdv, {8'h00, dv[k][23:0]});
    end
    ahb(1'b0, 12'(rmc_pkg::MEM_BASE + rmc_pkg::VREG_BYTES * mi[1] + 2), 3'h1, 32'h0);
    check("memory half read", rdv, lane({8'h00, dv[1][23:0]}, 2'h2, 3'h1));
    foreach (holes[k]) begin
      rd(holes[k]);
      check("unmapped resp", rsp, 1'b1);
    end
    close_out();
  end
endmodule

// ==== verilog/rmc_core.sv ====
// Register map core: AHB-Lite slave with interrupt summaries, alias, shared, external and memory windows.
//
// Function
// - Interrupt summary ORs enabled, unmasked interrupt bits.
// - Stop summary ORs halt-enabled, unmasked interrupt bits.
// - Stop output only where halt gating exists.
// - Interrupt summary always present on interrupt register.
// - Register widths power of two, eight or more.
// - Access width power of two, within register.
// - Missing access width means full register width.
// - Partial reads without side effects return subword.
// - Writable fields never straddle access subwords.
// - External error input yields bus error response.
// - Shared register holds one state for maps.
// - Size-only fields pack contiguously from numbering origin; here field C starts at index 8, not 4, in both layouts.
// - Range order picks numbering; left index is MSB.
// - Interrupt summary feeds another register's field.
// - All decoding uses byte addresses.
// - Virtual register width: power-of-two bytes holding entry.
// - Virtual registers inherit memory access, no hardware.
// - Virtual registers fit memory without overlap.
// - Alias acts on primary's physical register.
//
// The register offsets and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/1ps
module rmc_core (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [rmc_pkg::EVT_W-1:0] evt,
  output logic intr_summary,
  output logic halt_summary,
  input wire logic b_wr,
  input wire logic [rmc_pkg::REG_W-1:0] b_wdata,
  output logic [rmc_pkg::REG_W-1:0] b_rdata,
  output logic ext_req,
  output logic ext_we,
  output logic [rmc_pkg::EXT_IDX_W-1:0] ext_idx,
  output logic [rmc_pkg::REG_W-1:0] ext_wdata,
  input wire logic [rmc_pkg::REG_W-1:0] ext_rdata,
  input wire logic ext_ack,
  input wire logic ext_err,
  output logic mem_req,
  output logic mem_we,
  output logic [rmc_pkg::MEM_IDX_W-1:0] mem_idx,
  output logic [rmc_pkg::MEM_ENTRY_W-1:0] mem_wdata,
  input wire logic [rmc_pkg::MEM_ENTRY_W-1:0] mem_rdata,
  input wire logic mem_ack
);
  localparam rmc_pkg::rmc_state_s S_RESET = '{st: rmc_pkg::ST_IDLE, hreadyout: 1'b1, default: '0};

  rmc_pkg::rmc_state_s s_r;
  rmc_pkg::rmc_state_s s_nxt;

  // Byte lanes that a transfer of the given size and alignment covers.
  function automatic logic [31:0] lane_mask(input logic [2:0] size, input logic [1:0] a);
    logic [31:0] m;
    m = 32'hFFFFFFFF;
    if (size == 3'h0) begin
      m = 32'h000000FF << {a, 3'h0};
    end else if (size == 3'h1) begin
      m = 32'h0000FFFF << {a[1], 4'h0};
    end
    return m;
  endfunction

  function automatic logic in_window(input logic [rmc_pkg::ADDR_W-1:0] a,
                                     input logic [rmc_pkg::ADDR_W-1:0] base, input int size);
    return ({20'h0, a} >= {20'h0, base}) && ({20'h0, a} < ({20'h0, base} + 32'(size)));
  endfunction

  logic [rmc_pkg::EVT_W-1:0] intr_bits;
  logic [rmc_pkg::EVT_W-1:0] halt_bits;
  logic in_ext;
  logic in_mem;
  logic local_hit;
  logic word_acc;
  logic [rmc_pkg::REG_W-1:0] local_rd;
  logic [rmc_pkg::ADDR_W-1:0] mem_off;
  logic [rmc_pkg::ADDR_W-1:0] ext_off;
  logic [rmc_pkg::EVT_W-1:0] clr;

  always_comb begin
    intr_bits = s_r.status & s_r.enable & ~s_r.mask;
    halt_bits = s_r.status & s_r.halt_en & ~s_r.halt_mask;
    in_ext = in_window(s_r.addr, rmc_pkg::EXT_BASE, rmc_pkg::EXT_SIZE);
    in_mem = in_window(s_r.addr, rmc_pkg::MEM_BASE, rmc_pkg::MEM_SIZE);
    mem_off = s_r.addr - rmc_pkg::MEM_BASE;
    ext_off = s_r.addr - rmc_pkg::EXT_BASE;
    // Access width equals register width where none is given, so only word writes land.
    word_acc = (s_r.size == rmc_pkg::HSIZE_WORD);
    local_hit = 1'b1;
    local_rd = '0;
    case ({s_r.addr[rmc_pkg::ADDR_W-1:rmc_pkg::WORD_SHIFT], 2'h0})
      rmc_pkg::OFF_STATUS: local_rd = 32'(s_r.status);
      rmc_pkg::OFF_ALIAS: local_rd = 32'(s_r.status);
      rmc_pkg::OFF_ENABLE: local_rd = 32'(s_r.enable);
      rmc_pkg::OFF_MASK: local_rd = 32'(s_r.mask);
      rmc_pkg::OFF_HALT_EN: local_rd = 32'(s_r.halt_en);
      rmc_pkg::OFF_HALT_MASK: local_rd = 32'(s_r.halt_mask);
      rmc_pkg::OFF_CAPTURE: local_rd = 32'(s_r.capture);
      rmc_pkg::OFF_SCR_LO: local_rd = s_r.scratch[rmc_pkg::SCR_ACC_W-1:0];
      rmc_pkg::OFF_SCR_HI: local_rd = s_r.scratch[rmc_pkg::SCR_W-1:rmc_pkg::SCR_ACC_W];
      rmc_pkg::OFF_SHARED: local_rd = s_r.shared;
      rmc_pkg::OFF_LOWF: local_rd = s_r.lowf;
      rmc_pkg::OFF_HIGHF: local_rd = s_r.highf;
      default: local_hit = 1'b0;
    endcase
  end

  always_comb begin
    s_nxt = s_r;
    clr = '0;
    s_nxt.ext.req = 1'b0;
    s_nxt.mem.req = 1'b0;
    s_nxt.intr = |intr_bits;
    s_nxt.halt = |halt_bits;
    s_nxt.capture = |intr_bits;
    // Map B writes the shared register; a bus write in the same cycle overrides it below.
    if (b_wr) begin
      s_nxt.shared = b_wdata;
    end
    case (s_r.st)
      rmc_pkg::ST_IDLE: begin
        s_nxt.hresp = 1'b0;
        if (hsel && hready && htrans == rmc_pkg::HTRANS_NONSEQ) begin
          s_nxt.addr = haddr[rmc_pkg::ADDR_W-1:0];
          s_nxt.write = hwrite;
          s_nxt.size = hsize;
          s_nxt.hreadyout = 1'b0;
          s_nxt.st = rmc_pkg::ST_DATA;
        end
      end
      rmc_pkg::ST_DATA: begin
        if (in_ext || in_mem) begin
          s_nxt.tgt_mem = in_mem;
          if (s_r.write && !word_acc) begin
            s_nxt.hreadyout = 1'b1;
            s_nxt.st = rmc_pkg::ST_IDLE;
          end else if (in_mem) begin
            // Storage is outside; only the entry bits travel, the pad byte is dropped.
            s_nxt.mem.req = 1'b1;
            s_nxt.mem.we = s_r.write;
            s_nxt.mem.idx = mem_off[rmc_pkg::MEM_IDX_W+rmc_pkg::WORD_SHIFT-1:rmc_pkg::WORD_SHIFT];
            s_nxt.mem.wdata = hwdata[rmc_pkg::MEM_ENTRY_W-1:0];
            s_nxt.st = rmc_pkg::ST_EXT;
          end else begin
            s_nxt.ext.req = 1'b1;
            s_nxt.ext.we = s_r.write;
            s_nxt.ext.idx = ext_off[rmc_pkg::EXT_IDX_W+rmc_pkg::WORD_SHIFT-1:rmc_pkg::WORD_SHIFT];
            s_nxt.ext.wdata = hwdata;
            s_nxt.st = rmc_pkg::ST_EXT;
          end
        end else if (local_hit) begin
          s_nxt.hreadyout = 1'b1;
          s_nxt.st = rmc_pkg::ST_IDLE;
          if (!s_r.write) begin
            s_nxt.hrdata = local_rd & lane_mask(s_r.size, s_r.addr[1:0]);
          end else if (word_acc) begin
            case ({s_r.addr[rmc_pkg::ADDR_W-1:rmc_pkg::WORD_SHIFT], 2'h0})
              rmc_pkg::OFF_STATUS: clr = hwdata[rmc_pkg::EVT_W-1:0];
              rmc_pkg::OFF_ALIAS: s_nxt.status = hwdata[rmc_pkg::EVT_W-1:0];
              rmc_pkg::OFF_ENABLE: s_nxt.enable = hwdata[rmc_pkg::EVT_W-1:0];
              rmc_pkg::OFF_MASK: s_nxt.mask = hwdata[rmc_pkg::EVT_W-1:0];
              rmc_pkg::OFF_HALT_EN: s_nxt.halt_en = hwdata[rmc_pkg::EVT_W-1:0];
              rmc_pkg::OFF_HALT_MASK: s_nxt.halt_mask = hwdata[rmc_pkg::EVT_W-1:0];
              // Each 32-bit half is its own access subword, so no writable field spans both.
              rmc_pkg::OFF_SCR_LO: s_nxt.scratch[rmc_pkg::SCR_ACC_W-1:0] = hwdata;
              rmc_pkg::OFF_SCR_HI: s_nxt.scratch[rmc_pkg::SCR_W-1:rmc_pkg::SCR_ACC_W] = hwdata;
              rmc_pkg::OFF_SHARED: s_nxt.shared = hwdata;
              rmc_pkg::OFF_LOWF: s_nxt.lowf = hwdata & rmc_pkg::LF_MASK;
              rmc_pkg::OFF_HIGHF: s_nxt.highf = hwdata & rmc_pkg::HF_MASK;
              default: clr = '0;
            endcase
          end
        end else begin
          s_nxt.hresp = 1'b1;
          s_nxt.st = rmc_pkg::ST_ERR;
        end
      end
      rmc_pkg::ST_EXT: begin
        if (s_r.tgt_mem && mem_ack) begin
          s_nxt.hrdata = 32'(mem_rdata) & lane_mask(s_r.size, s_r.addr[1:0]);
          s_nxt.hreadyout = 1'b1;
          s_nxt.st = rmc_pkg::ST_IDLE;
        end else if (!s_r.tgt_mem && ext_ack) begin
          s_nxt.hrdata = ext_rdata & lane_mask(s_r.size, s_r.addr[1:0]);
          if (ext_err) begin
            s_nxt.hresp = 1'b1;
            s_nxt.st = rmc_pkg::ST_ERR;
          end else begin
            s_nxt.hreadyout = 1'b1;
            s_nxt.st = rmc_pkg::ST_IDLE;
          end
        end
      end
      rmc_pkg::ST_ERR: begin
        // Second cycle of the two-cycle error answer.
        s_nxt.hreadyout = 1'b1;
        s_nxt.st = rmc_pkg::ST_IDLE;
      end
      default: begin
        s_nxt = S_RESET;
      end
    endcase
    // A new event beats a clear in the same cycle so it is never lost.
    s_nxt.status = (s_nxt.status & ~clr) | evt;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r <= S_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign hreadyout = s_r.hreadyout;
  assign hresp = s_r.hresp;
  assign hrdata = s_r.hrdata;
  assign intr_summary = s_r.intr;
  assign halt_summary = s_r.halt;
  assign b_rdata = s_r.shared;
  assign ext_req = s_r.ext.req;
  assign ext_we = s_r.ext.we;
  assign ext_idx = s_r.ext.idx;
  assign ext_wdata = s_r.ext.wdata;
  assign mem_req = s_r.mem.req;
  assign mem_we = s_r.mem.we;
  assign mem_idx = s_r.mem.idx;
  assign mem_wdata = s_r.mem.wdata;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  logic bus_shared_wr;
  assign bus_shared_wr = (s_r.st == rmc_pkg::ST_DATA) && s_r.write && word_acc &&
    ({s_r.addr[rmc_pkg::ADDR_W-1:rmc_pkg::WORD_SHIFT], 2'h0} == rmc_pkg::OFF_SHARED);

  a_intr_summary: assert property (intr_summary == $past(|(s_r.status & s_r.enable & ~s_r.mask)))
    else $error("interrupt summary does not match gated bits");
  a_halt_summary: assert property (##1 halt_summary == $past(|(s_r.status & s_r.halt_en & ~s_r.halt_mask)))
    else $error("stop summary does not match gated bits");
  a_intr_no_gating: assert property ((s_r.mask == '0 && (s_r.status & s_r.enable) != '0) |=> intr_summary)
    else $error("interrupt summary missing with no mask");
  a_capture_field: assert property (s_r.capture == intr_summary)
    else $error("capture field did not follow interrupt summary");
  a_width_legal: assert property (rmc_pkg::is_pow2_min8(rmc_pkg::REG_W) &&
    rmc_pkg::is_pow2_min8(rmc_pkg::SCR_W) && rmc_pkg::is_pow2_min8(rmc_pkg::SCR_ACC_W) &&
    rmc_pkg::SCR_ACC_W <= rmc_pkg::SCR_W && rmc_pkg::DEF_ACC_W == rmc_pkg::REG_W)
    else $error("register or access width illegal");
  a_ext_error: assert property ((s_r.st == rmc_pkg::ST_EXT && !s_r.tgt_mem && ext_ack && ext_err) |=>
    (hresp && !hreadyout) ##1 (hresp && hreadyout))
    else $error("external error not answered as two-cycle error");
  a_alias_write: assert property ((s_r.st == rmc_pkg::ST_DATA && s_r.write && word_acc &&
    {s_r.addr[rmc_pkg::ADDR_W-1:rmc_pkg::WORD_SHIFT], 2'h0} == rmc_pkg::OFF_ALIAS) |=>
    s_r.status == ($past(hwdata[rmc_pkg::EVT_W-1:0]) | $past(evt)))
    else $error("alias write did not reach primary register");
  a_shared_map_b: assert property ((b_wr && !bus_shared_wr) |=> b_rdata == $past(b_wdata))
    else $error("shared register not updated from second map");
  a_mem_read_pad: assert property ((s_r.st == rmc_pkg::ST_EXT && s_r.tgt_mem && mem_ack) |=>
    hreadyout && hrdata[rmc_pkg::REG_W-1:rmc_pkg::MEM_ENTRY_W] == '0)
    else $error("virtual register pad bits not zero");
  a_mem_forward: assert property ((s_r.st == rmc_pkg::ST_DATA && in_mem && (!s_r.write || word_acc)) |=>
    mem_req ##1 !mem_req)
    else $error("memory window access not forwarded once");
  a_narrow_write: assert property ((s_r.st == rmc_pkg::ST_DATA && s_r.write && !word_acc) |=>
    s_r.scratch == $past(s_r.scratch) && s_r.enable == $past(s_r.enable))
    else $error("write narrower than access width changed a register");
  a_set_wins: assert property ((s_r.st == rmc_pkg::ST_DATA && s_r.write && word_acc && evt != '0 &&
    {s_r.addr[rmc_pkg::ADDR_W-1:rmc_pkg::WORD_SHIFT], 2'h0} == rmc_pkg::OFF_STATUS) |=>
    (s_r.status & $past(evt)) == $past(evt))
    else $error("event lost under clear");

  c_local_write: cover property (s_r.st == rmc_pkg::ST_DATA && s_r.write && local_hit && word_acc);
  c_ext_error: cover property (s_r.st == rmc_pkg::ST_EXT && ext_ack && ext_err);
  c_mem_read: cover property (s_r.st == rmc_pkg::ST_EXT && s_r.tgt_mem && mem_ack && !s_r.write);
  c_halt_raise: cover property ($rose(halt_summary));
endmodule

// ==== verilog/rmc_pkg.sv ====
// Constants, field layouts and state types of the register map core.
package rmc_pkg;
  localparam int REG_W = 32;
  localparam int ADDR_W = 12;
  localparam int EVT_W = 4;
  localparam int SCR_W = 64;
  localparam int SCR_ACC_W = 32;
  localparam int DEF_ACC_W = REG_W;

  localparam logic [ADDR_W-1:0] OFF_STATUS = 12'h000;
  localparam logic [ADDR_W-1:0] OFF_ENABLE = 12'h004;
  localparam logic [ADDR_W-1:0] OFF_MASK = 12'h008;
  localparam logic [ADDR_W-1:0] OFF_HALT_EN = 12'h00C;
  localparam logic [ADDR_W-1:0] OFF_HALT_MASK = 12'h010;
  localparam logic [ADDR_W-1:0] OFF_CAPTURE = 12'h014;
  localparam logic [ADDR_W-1:0] OFF_ALIAS = 12'h018;
  localparam logic [ADDR_W-1:0] OFF_SCR_LO = 12'h020;
  localparam logic [ADDR_W-1:0] OFF_SCR_HI = 12'h024;
  localparam logic [ADDR_W-1:0] OFF_SHARED = 12'h028;
  localparam logic [ADDR_W-1:0] OFF_LOWF = 12'h02C;
  localparam logic [ADDR_W-1:0] OFF_HIGHF = 12'h030;
  localparam logic [ADDR_W-1:0] EXT_BASE = 12'h040;
  localparam int EXT_REGS = 16;
  localparam int EXT_IDX_W = 4;
  localparam logic [ADDR_W-1:0] MEM_BASE = 12'h100;
  localparam int MEM_ENTRY_W = 24;
  localparam int MEM_ENTRIES = 64;
  localparam int MEM_IDX_W = 6;
  localparam int WORD_SHIFT = 2;

  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  function automatic int pow2_bytes(input int bits);
    int b;
    b = 1;
    while (b * 8 < bits) b = b * 2;
    return b;
  endfunction

  function automatic bit is_pow2_min8(input int w);
    return (w >= 8) && ((w & (w - 1)) == 0);
  endfunction

  function automatic logic [REG_W-1:0] fmask(input int lsb, input int w);
    logic [REG_W-1:0] m;
    m = '0;
    for (int i = 0; i < w; i++) m[lsb+i] = 1'b1;
    return m;
  endfunction

  // High-first index idx names the field's most significant bit.
  function automatic int hf_lsb(input int idx, input int w);
    return REG_W - 1 - (idx + w - 1);
  endfunction

  localparam int VREG_BYTES = pow2_bytes(MEM_ENTRY_W);
  localparam int EXT_SIZE = EXT_REGS * (REG_W / 8);
  localparam int MEM_SIZE = MEM_ENTRIES * VREG_BYTES;

  localparam int LF_A_LSB = 0;
  localparam int LF_A_W = 1;
  localparam int LF_B_LSB = LF_A_LSB + LF_A_W;
  localparam int LF_B_W = 3;
  localparam int LF_C_LSB = 8;
  localparam int LF_C_W = 8;
  localparam int LF_D_LSB = LF_C_LSB + LF_C_W;
  localparam int LF_D_W = 5;
  localparam logic [REG_W-1:0] LF_MASK = fmask(LF_A_LSB, LF_A_W) | fmask(LF_B_LSB, LF_B_W) |
    fmask(LF_C_LSB, LF_C_W) | fmask(LF_D_LSB, LF_D_W);

  localparam int HF_A_IDX = 0;
  localparam int HF_A_W = 1;
  localparam int HF_B_IDX = HF_A_IDX + HF_A_W;
  localparam int HF_B_W = 3;
  localparam int HF_C_IDX = 8;
  localparam int HF_C_W = 8;
  localparam int HF_D_IDX = HF_C_IDX + HF_C_W;
  localparam int HF_D_W = 5;
  localparam logic [REG_W-1:0] HF_MASK = fmask(hf_lsb(HF_A_IDX, HF_A_W), HF_A_W) |
    fmask(hf_lsb(HF_B_IDX, HF_B_W), HF_B_W) | fmask(hf_lsb(HF_C_IDX, HF_C_W), HF_C_W) |
    fmask(hf_lsb(HF_D_IDX, HF_D_W), HF_D_W);

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_DATA = 2'h1,
    ST_EXT = 2'h3,
    ST_ERR = 2'h2
  } rmc_state_e;

  typedef struct packed {
    logic req;
    logic we;
    logic [EXT_IDX_W-1:0] idx;
    logic [REG_W-1:0] wdata;
  } rmc_ext_req_s;

  typedef struct packed {
    logic req;
    logic we;
    logic [MEM_IDX_W-1:0] idx;
    logic [MEM_ENTRY_W-1:0] wdata;
  } rmc_mem_req_s;

  typedef struct packed {
    rmc_state_e st;
    logic hreadyout;
    logic hresp;
    logic [REG_W-1:0] hrdata;
    logic [ADDR_W-1:0] addr;
    logic write;
    logic [2:0] size;
    logic tgt_mem;
    logic [EVT_W-1:0] status;
    logic [EVT_W-1:0] enable;
    logic [EVT_W-1:0] mask;
    logic [EVT_W-1:0] halt_en;
    logic [EVT_W-1:0] halt_mask;
    logic capture;
    logic [SCR_W-1:0] scratch;
    logic [REG_W-1:0] shared;
    logic [REG_W-1:0] lowf;
    logic [REG_W-1:0] highf;
    logic intr;
    logic halt;
    rmc_ext_req_s ext;
    rmc_mem_req_s mem;
  } rmc_state_s;
endpackage
